// ==== design/pita_pkg.sv ====
// constants and register map of the interrupt and trap arbiter
package pita_pkg;
    localparam int NVEC = 80;
    localparam int FIRST_SRC = 8;
    localparam int NTRAP = 5;
    localparam int VEC_W = 7;
    localparam int LVL_W = 4;
    localparam int ADDR_W = 24;
    localparam int ST_W = 3;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LEVEL_OFS = 8'h04;
    localparam logic [7:0] TRAP_OFS = 8'h08;
    localparam logic [7:0] SUP_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    localparam logic [7:0] LAST_OFS = 8'h18;
    localparam logic [7:0] FLAG_OFS = 8'h20;
    localparam logic [7:0] EN_OFS = 8'h30;
    localparam logic [7:0] PRIO_OFS = 8'h40;
    // field positions
    localparam int NSTD_BIT = 15;
    localparam int ALT_BIT = 8;
    localparam int TRAP_LSB = 1;
    localparam int SUP_ACT_BIT = 16;
    localparam int LAST_LVL_LSB = 8;
    localparam int PRIO_NIB = 4;
    localparam int ST_IRQ_ACC = 0;
    localparam int ST_TRAP_ACC = 1;
    localparam int ST_SUP_END = 2;
    // levels
    localparam logic [3:0] LVL_RST = 4'h0;
    localparam logic [3:0] LVL_MASK_ALL = 4'h7;
    localparam logic [3:0] LVL_SUP_CEIL = 4'h6;
    localparam logic [3:0] TRAP_LVL_TOP = 4'hC;
    // vector table layout and control register reset value
    localparam logic [23:0] TABLE_BASE = 24'h000004;
    localparam logic [23:0] ALT_IRQ_STEP = 24'h000100;
    localparam logic [23:0] ALT_TRAP_STEP = 24'h000080;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
endpackage : pita_pkg

// ==== design/pita_top.sv ====
// interrupt and trap arbiter with apb register file and core vector port
//
// Overview of operation
// - each source has level 0..7, zero disables
// - equal levels resolved by smallest vector number
// - nesting default: strictly higher level preempts
// - nesting disabled: interrupt accept forces cpu level 7, trap accept sets the trap level
// - nesting disabled: levels only order simultaneous requests
// - nesting disabled: cpu level not writable
// - traps non-maskable, fixed order, vectors 1..5
// - exception taken only at instruction boundary
// - software-set flag of enabled source interrupts
// - primary and alternate tables, step two
// - vector numbers fixed per source position
// - timed suppress masks level 6 and below
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module pita_top #(
    parameter int SUP_W = 14
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources, irq_event index is the vector number; trap_event bit i is vector i+1
    input wire logic [pita_pkg::NVEC-1:0] irq_event,
    input wire logic [pita_pkg::NTRAP-1:0] trap_event,
    // core sequencer
    input wire logic instr_boundary,
    input wire logic exc_accept,
    input wire logic return_from_interrupt,
    input wire logic [pita_pkg::LVL_W-1:0] return_level,
    output logic exc_valid,
    output logic [pita_pkg::VEC_W-1:0] exc_vector,
    output logic [pita_pkg::ADDR_W-1:0] exc_addr,
    output logic [pita_pkg::LVL_W-1:0] exc_level,
    output logic [2:0] cpu_priority_level,
    output logic suppress_active,
    // interrupt to system
    output logic irq
);
    import pita_pkg::*;

    localparam int NFW = (NVEC + 31) / 32;
    localparam int NPW = (NVEC + 7) / 8;

    logic [NVEC-1:0] flag_r;
    logic [NVEC-1:0] en_r;
    logic [2:0] prio_r [NVEC];
    logic [NFW*32-1:0] flag_pad;
    logic [NFW*32-1:0] en_pad;
    logic [NPW*32-1:0] prio_pad;
    logic [31:0] ctrl_r;
    logic [LVL_W-1:0] cur_lvl_r;
    logic [NTRAP-1:0] trap_r;
    logic [SUP_W-1:0] sup_cnt_r;
    logic [ST_W-1:0] st_r;
    logic [ST_W-1:0] mask_r;
    logic [VEC_W-1:0] last_vec_r;
    logic [LVL_W-1:0] last_lvl_r;
    logic win_valid_r;
    logic [VEC_W-1:0] win_vec_r;
    logic [LVL_W-1:0] win_lvl_r;
    logic [ADDR_W-1:0] win_addr_r;
    logic hold_r;
    logic [31:0] prdata_r;

    logic nest_dis;
    logic alt_sel;
    logic addr_hit;
    logic wr;
    logic [31:0] rdat;
    logic [NFW-1:0] wr_flag;
    logic [NFW-1:0] wr_en;
    logic [NPW-1:0] wr_prio;
    logic lvl_wr;
    logic take;
    logic take_trap;
    logic best_found;
    logic [VEC_W-1:0] best_vec;
    logic [LVL_W-1:0] best_lvl;
    logic [ADDR_W-1:0] best_addr;
    logic [ST_W-1:0] st_ev;

    assign nest_dis = ctrl_r[NSTD_BIT];
    assign alt_sel = ctrl_r[ALT_BIT];
    assign suppress_active = (sup_cnt_r != '0);
    assign cpu_priority_level = cur_lvl_r[2:0];

    // ---------------- apb decode ----------------
    always_comb begin
        addr_hit = 1'b1;
        rdat = 32'h00000000;
        if (paddr == CTRL_OFS) begin
            rdat = ctrl_r;
        end else if (paddr == LEVEL_OFS) begin
            rdat = {28'h0000000, cur_lvl_r};
        end else if (paddr == TRAP_OFS) begin
            rdat = {26'h0000000, trap_r, 1'b0};
        end else if (paddr == SUP_OFS) begin
            rdat[SUP_W-1:0] = sup_cnt_r;
            rdat[SUP_ACT_BIT] = suppress_active;
        end else if (paddr == STAT_OFS) begin
            rdat[ST_W-1:0] = st_r;
        end else if (paddr == MASK_OFS) begin
            rdat[ST_W-1:0] = mask_r;
        end else if (paddr == LAST_OFS) begin
            rdat = {20'h00000, last_lvl_r, 1'b0, last_vec_r};
        end else if (paddr >= FLAG_OFS && paddr < FLAG_OFS + 8'(4 * NFW)
            && paddr[1:0] == 2'h0) begin
            rdat = flag_pad[32 * int'((paddr - FLAG_OFS) >> 2) +: 32];
        end else if (paddr >= EN_OFS && paddr < EN_OFS + 8'(4 * NFW) && paddr[1:0] == 2'h0) begin
            rdat = en_pad[32 * int'((paddr - EN_OFS) >> 2) +: 32];
        end else if (paddr >= PRIO_OFS && paddr < PRIO_OFS + 8'(4 * NPW)
            && paddr[1:0] == 2'h0) begin
            rdat = prio_pad[32 * int'((paddr - PRIO_OFS) >> 2) +: 32];
        end else begin
            addr_hit = 1'b0;
        end
    end

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign wr = psel & penable & pwrite & addr_hit;
    assign prdata = prdata_r;
    assign lvl_wr = wr && paddr == LEVEL_OFS && !nest_dis;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_r <= rdat;
        end
    end

    always_comb begin
        for (int k = 0; k < NFW; k++) begin
            wr_flag[k] = wr && paddr == FLAG_OFS + 8'(4 * k);
            wr_en[k] = wr && paddr == EN_OFS + 8'(4 * k);
        end
        for (int k = 0; k < NPW; k++) begin
            wr_prio[k] = wr && paddr == PRIO_OFS + 8'(4 * k);
        end
    end

    // ---------------- per-source state ----------------
    assign flag_pad[NFW*32-1:NVEC] = '0;
    assign en_pad[NFW*32-1:NVEC] = '0;
    for (genvar g = 0; g < NVEC; g++) begin : g_src
        assign flag_pad[g] = flag_r[g];
        assign en_pad[g] = en_r[g];
        assign prio_pad[g*PRIO_NIB +: PRIO_NIB] = {1'b0, prio_r[g]};
        if (g < FIRST_SRC) begin : g_trapslot
            // vectors below eight belong to traps and hold no source state
            assign flag_r[g] = 1'b0;
            assign en_r[g] = 1'b0;
            assign prio_r[g] = 3'h0;
        end else begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_r[g] <= 1'b0;
                end else begin
                    // software may set a flag itself; a peripheral event wins over a clear
                    flag_r[g] <= (wr_flag[g/32] ? pwdata[g%32] : flag_r[g]) | irq_event[g];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_r[g] <= 1'b0;
                end else if (wr_en[g/32]) begin
                    en_r[g] <= pwdata[g%32];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prio_r[g] <= 3'h0;
                end else if (wr_prio[g/8]) begin
                    prio_r[g] <= pwdata[(g%8)*PRIO_NIB +: 3];
                end
            end
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr && paddr == CTRL_OFS) begin
            ctrl_r <= pwdata & ((32'h1 << NSTD_BIT) | (32'h1 << ALT_BIT));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_r <= '0;
        end else begin
            // set wins over the write-one clear
            trap_r <= (trap_r & ~((wr && paddr == TRAP_OFS) ? pwdata[TRAP_LSB +: NTRAP] : '0))
                | trap_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_cnt_r <= '0;
        end else if (wr && paddr == SUP_OFS) begin
            sup_cnt_r <= pwdata[SUP_W-1:0];
        end else if (suppress_active) begin
            sup_cnt_r <= sup_cnt_r - 1'b1;
        end
    end

    // cpu level: an accepted exception beats a return, which beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_lvl_r <= LVL_RST;
        end else if (take) begin
            if (nest_dis && !take_trap) begin
                cur_lvl_r <= LVL_MASK_ALL;
            end else begin
                cur_lvl_r <= win_lvl_r;
            end
        end else if (return_from_interrupt) begin
            cur_lvl_r <= return_level;
        end else if (lvl_wr) begin
            cur_lvl_r <= {1'b0, pwdata[2:0]};
        end
    end

    // ---------------- arbitration ----------------
    // scanning downward with >= lets the smaller vector win a tie
    always_comb begin
        logic [LVL_W-1:0] lv;
        lv = '0;
        best_found = 1'b0;
        best_vec = '0;
        best_lvl = '0;
        for (int i = NTRAP - 1; i >= 0; i--) begin
            lv = TRAP_LVL_TOP - LVL_W'(i);
            if (trap_r[i] && lv > cur_lvl_r) begin
                best_found = 1'b1;
                best_vec = VEC_W'(i + 1);
                best_lvl = lv;
            end
        end
        if (!best_found) begin
            for (int v = NVEC - 1; v >= FIRST_SRC; v--) begin
                lv = {1'b0, prio_r[v]};
                if (flag_r[v] && en_r[v] && lv != LVL_RST && lv > cur_lvl_r
                    && !(suppress_active && lv <= LVL_SUP_CEIL)
                    && lv >= best_lvl) begin
                    best_found = 1'b1;
                    best_vec = VEC_W'(v);
                    best_lvl = lv;
                end
            end
        end
    end

    // table entries are two address units apart; alternate copies sit above
    always_comb begin
        best_addr = TABLE_BASE + {16'h0000, best_vec, 1'b0};
        if (alt_sel) begin
            best_addr = best_addr
                + ((best_vec < VEC_W'(FIRST_SRC)) ? ALT_TRAP_STEP : ALT_IRQ_STEP);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_valid_r <= 1'b0;
            win_vec_r <= '0;
            win_lvl_r <= '0;
            win_addr_r <= '0;
        end else begin
            win_valid_r <= best_found;
            win_vec_r <= best_vec;
            win_lvl_r <= best_lvl;
            win_addr_r <= best_addr;
        end
    end

    // the registered winner is one cycle stale after any level change or register write;
    // without this a source just disabled or cleared could still be presented once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= take | return_from_interrupt | wr;
        end
    end

    // the core finishes the faulting instruction before this can rise
    assign exc_valid = win_valid_r & instr_boundary & ~hold_r;
    assign exc_vector = win_vec_r;
    assign exc_addr = win_addr_r;
    assign exc_level = win_lvl_r;
    assign take = exc_valid & exc_accept;
    assign take_trap = win_vec_r < VEC_W'(FIRST_SRC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_vec_r <= '0;
            last_lvl_r <= '0;
        end else if (take) begin
            last_vec_r <= win_vec_r;
            last_lvl_r <= win_lvl_r;
        end
    end

    // ---------------- event status and interrupt ----------------
    always_comb begin
        st_ev = '0;
        st_ev[ST_IRQ_ACC] = take & ~take_trap;
        st_ev[ST_TRAP_ACC] = take & take_trap;
        st_ev[ST_SUP_END] = (sup_cnt_r == SUP_W'(1)) && !(wr && paddr == SUP_OFS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= (st_r & ~((wr && paddr == STAT_OFS) ? pwdata[ST_W-1:0] : '0)) | st_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr && paddr == MASK_OFS) begin
            mask_r <= pwdata[ST_W-1:0];
        end
    end

    assign irq = |(st_r & mask_r);

    // ---------------- checks ----------------
    property p_zero_off;
        @(posedge pclk) disable iff (!presetn)
        exc_valid && !take_trap |-> win_lvl_r != LVL_RST && prio_r[win_vec_r] != 3'h0;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("disabled source presented");

    property p_above_cpu;
        @(posedge pclk) disable iff (!presetn)
        exc_valid |-> win_lvl_r > cur_lvl_r;
    endproperty
    a_above_cpu: assert property (p_above_cpu) else $error("level not above cpu");

    property p_nest_force;
        @(posedge pclk) disable iff (!presetn)
        take && nest_dis && !take_trap |=> cur_lvl_r == LVL_MASK_ALL;
    endproperty
    a_nest_force: assert property (p_nest_force) else $error("level not forced to 7");

    property p_nest_on;
        @(posedge pclk) disable iff (!presetn)
        take && !nest_dis |=> cur_lvl_r == $past(win_lvl_r);
    endproperty
    a_nest_on: assert property (p_nest_on) else $error("level not raised to winner");

    property p_lvl_locked;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == LEVEL_OFS && nest_dis && !take && !return_from_interrupt
        |=> $stable(cur_lvl_r);
    endproperty
    a_lvl_locked: assert property (p_lvl_locked) else $error("level written while locked");

    property p_boundary;
        @(posedge pclk) disable iff (!presetn)
        exc_valid |-> instr_boundary;
    endproperty
    a_boundary: assert property (p_boundary) else $error("exception off boundary");

    property p_osc_first;
        @(posedge pclk) disable iff (!presetn)
        trap_r[0] && TRAP_LVL_TOP > cur_lvl_r |=> win_valid_r && win_vec_r == 7'h01;
    endproperty
    a_osc_first: assert property (p_osc_first) else $error("oscillator trap not first");

    property p_alt_addr;
        @(posedge pclk) disable iff (!presetn)
        exc_valid && alt_sel && !take_trap
        |-> exc_addr == 24'h000104 + {16'h0000, exc_vector, 1'b0};
    endproperty
    a_alt_addr: assert property (p_alt_addr) else $error("alternate address wrong");

    property p_suppress;
        @(posedge pclk) disable iff (!presetn)
        suppress_active && $past(suppress_active) && exc_valid |-> win_lvl_r > LVL_SUP_CEIL;
    endproperty
    a_suppress: assert property (p_suppress) else $error("low level during suppress");

    c_trap: cover property (@(posedge pclk) disable iff (!presetn) take && take_trap);
    c_nested: cover property (@(posedge pclk) disable iff (!presetn)
        take && !take_trap ##[1:50] take && !take_trap);
    c_sup: cover property (@(posedge pclk) disable iff (!presetn) st_ev[ST_SUP_END]);
endmodule : pita_top

// ==== verif/pita_core_model.sv ====
// behavioural cpu core sequencer facing the arbiter's vector port
`timescale 1ns/1ns
module pita_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic accept_en,
    input wire logic stall,
    input wire logic slow,
    input wire logic ret_go,
    input wire logic [pita_pkg::LVL_W-1:0] ret_lvl,
    // arbiter side
    input wire logic exc_valid,
    output logic instr_boundary,
    output logic exc_accept,
    output logic return_from_interrupt,
    output logic [pita_pkg::LVL_W-1:0] return_level
);
    import pita_pkg::*;
    logic [1:0] ph_r;
    // slow mode mimics multi-cycle instructions: a boundary only every third cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
        end else begin
            ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        end
    end
    // a faulting instruction keeps the boundary low until it completes
    assign instr_boundary = !stall && (!slow || ph_r == 2'h0);
    assign exc_accept = accept_en && exc_valid;
    assign return_from_interrupt = ret_go;
    assign return_level = ret_lvl;
endmodule : pita_core_model

// ==== verif/tb_priority_interrupt_trap_arbiter.sv ====
// self-checking bench for the interrupt and trap arbiter
`timescale 1ns/1ns
module tb_priority_interrupt_trap_arbiter;
    import pita_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [NVEC-1:0] irq_event;
    logic [NTRAP-1:0] trap_event;
    logic instr_boundary, exc_accept, return_from_interrupt, exc_valid;
    logic [LVL_W-1:0] return_level, exc_level, ret_lvl;
    logic [VEC_W-1:0] exc_vector;
    logic [ADDR_W-1:0] exc_addr;
    logic [2:0] cpu_priority_level;
    logic suppress_active, irq, accept_en, stall, slow, ret_go;
    logic [31:0] pr_m [10];
    logic [31:0] en_m [3];
    logic [31:0] fl_m [3];
    int fail_count, n_checks, cyc;

    pita_top #(.SUP_W(14)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
        .trap_event(trap_event), .instr_boundary(instr_boundary),
        .exc_accept(exc_accept), .return_from_interrupt(return_from_interrupt),
        .return_level(return_level), .exc_valid(exc_valid), .exc_vector(exc_vector),
        .exc_addr(exc_addr), .exc_level(exc_level),
        .cpu_priority_level(cpu_priority_level), .suppress_active(suppress_active),
        .irq(irq));
    pita_core_model i_core (.pclk(pclk), .presetn(presetn), .accept_en(accept_en),
        .stall(stall), .slow(slow), .ret_go(ret_go), .ret_lvl(ret_lvl),
        .exc_valid(exc_valid), .instr_boundary(instr_boundary), .exc_accept(exc_accept),
        .return_from_interrupt(return_from_interrupt), .return_level(return_level));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // whole run needs well under a thousand cycles; the ceiling leaves wide margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    task wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : wt

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task src(input int v, input logic [3:0] lvl, input logic f);
        pr_m[v/8][(v%8)*4 +: 4] = lvl;
        en_m[v/32][v%32] = 1'b1;
        fl_m[v/32][v%32] = f;
        apb(1'b1, PRIO_OFS + 8'(4*(v/8)), pr_m[v/8]);
        apb(1'b1, EN_OFS + 8'(4*(v/32)), en_m[v/32]);
        apb(1'b1, FLAG_OFS + 8'(4*(v/32)), fl_m[v/32]);
    endtask : src

    task win(input int v, input int lvl, input logic [23:0] ofs);
        chk("exc_valid", 32'h1, exc_valid);
        chk("exc_vector", v, exc_vector);
        chk("exc_addr", TABLE_BASE + 24'(2*v) + ofs, exc_addr);
        chk("exc_level", lvl, exc_level);
    endtask : win

    task ret(input logic [3:0] l);
        @(posedge pclk);
        ret_lvl <= l;
        ret_go <= 1'b1;
        @(posedge pclk);
        ret_go <= 1'b0;
    endtask : ret

    task rst;
        @(posedge pclk);
        presetn <= 1'b0;
        accept_en <= 1'b0;
        slow <= 1'b0;
        stall <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (pr_m[i]) pr_m[i] = 32'h0;
        foreach (en_m[i]) en_m[i] = 32'h0;
        foreach (fl_m[i]) fl_m[i] = 32'h0;
    endtask : rst

    task t_regs;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", CTRL_RST, rdat);
        apb(1'b0, LEVEL_OFS, 32'h0);
        chk("level", 32'h0, rdat);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("status", 32'h0, rdat);
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        chk("slverr_wr", 32'h1, rerr);
        apb(1'b0, 8'h1C, 32'h0);
        chk("slverr_rd", 32'h1, rerr);
        chk("unmapped", 32'h0, rdat);
        wt(1);
        chk("irq", 32'h0, irq);
    endtask : t_regs

    task t_prio;
        src(70, 4'h3, 1'b1);
        src(69, 4'h3, 1'b1);
        src(76, 4'h0, 1'b1);
        src(74, 4'h2, 1'b1);
        wt(3);
        win(69, 3, 24'h0);
        apb(1'b1, LEVEL_OFS, 32'h3);
        wt(3);
        chk("exc_valid", 32'h0, exc_valid);
        apb(1'b1, LEVEL_OFS, 32'h1);
        src(70, 4'h4, 1'b1);
        wt(3);
        win(70, 4, 24'h0);
        src(70, 4'h0, 1'b1);
        src(69, 4'h0, 1'b1);
        wt(3);
        win(74, 2, 24'h0);
        src(74, 4'h0, 1'b1);
        wt(3);
        chk("exc_valid", 32'h0, exc_valid);
    endtask : t_prio

    task t_trap;
        apb(1'b1, LEVEL_OFS, 32'h7);
        @(posedge pclk);
        stall <= 1'b1;
        trap_event <= '1;
        @(posedge pclk);
        trap_event <= '0;
        wt(3);
        chk("exc_valid", 32'h0, exc_valid);
        @(posedge pclk);
        stall <= 1'b0;
        for (int t = 1; t <= 5; t++) begin
            wt(3);
            win(t, 13 - t, 24'h0);
            apb(1'b1, TRAP_OFS, 32'h1 << t);
        end
        apb(1'b1, LEVEL_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1 << ALT_BIT);
        src(77, 4'h5, 1'b1);
        @(posedge pclk);
        trap_event <= 5'h01;
        @(posedge pclk);
        trap_event <= '0;
        wt(3);
        win(1, 12, ALT_TRAP_STEP);
        apb(1'b1, TRAP_OFS, 32'h2);
        wt(3);
        win(77, 5, ALT_IRQ_STEP);
        @(posedge pclk);
        accept_en <= 1'b1;
        trap_event <= 5'h01;
        @(posedge pclk);
        trap_event <= '0;
        wt(6);
        apb(1'b0, LAST_OFS, 32'h0);
        chk("last_trap", 32'h00000C01, rdat);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("status_trap", 32'h3, rdat);
    endtask : t_trap

    task t_nest;
        @(posedge pclk);
        slow <= 1'b1;
        accept_en <= 1'b1;
        src(20, 4'h2, 1'b1);
        wt(6);
        chk("cpu_level", 32'h2, cpu_priority_level);
        src(40, 4'h5, 1'b1);
        wt(6);
        chk("cpu_level", 32'h5, cpu_priority_level);
        src(30, 4'h5, 1'b0);
        @(posedge pclk);
        irq_event[30] <= 1'b1;
        @(posedge pclk);
        irq_event[30] <= 1'b0;
        wt(6);
        apb(1'b0, LAST_OFS, 32'h0);
        chk("last", 32'h00000528, rdat);
        ret(4'h2);
        wt(6);
        apb(1'b0, LAST_OFS, 32'h0);
        chk("last", 32'h0000051E, rdat);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("status_acc", 32'h1, rdat & 32'h1);
    endtask : t_nest

    task t_nstd;
        apb(1'b1, CTRL_OFS, 32'h1 << NSTD_BIT);
        @(posedge pclk);
        accept_en <= 1'b1;
        src(20, 4'h2, 1'b1);
        wt(4);
        chk("cpu_level", 32'h7, cpu_priority_level);
        src(40, 4'h5, 1'b1);
        wt(4);
        chk("exc_valid", 32'h0, exc_valid);
        apb(1'b1, LEVEL_OFS, 32'h0);
        wt(1);
        chk("cpu_level", 32'h7, cpu_priority_level);
        ret(4'h0);
        wt(4);
        apb(1'b0, LAST_OFS, 32'h0);
        chk("last_vec", 32'd40, rdat & 32'h7F);
        chk("cpu_level", 32'h7, cpu_priority_level);
    endtask : t_nstd

    task t_sup;
        apb(1'b1, MASK_OFS, 32'h4);
        apb(1'b1, SUP_OFS, 32'd60);
        wt(1);
        chk("suppress", 32'h1, suppress_active);
        src(40, 4'h6, 1'b1);
        wt(3);
        chk("exc_valid", 32'h0, exc_valid);
        src(41, 4'h7, 1'b1);
        wt(3);
        win(41, 7, 24'h0);
        chk("irq", 32'h0, irq);
        wt(60);
        chk("suppress", 32'h0, suppress_active);
        chk("irq", 32'h1, irq);
        apb(1'b1, MASK_OFS, 32'h0);
        wt(1);
        chk("irq", 32'h0, irq);
        apb(1'b1, MASK_OFS, 32'h4);
        apb(1'b1, STAT_OFS, 32'h4);
        wt(1);
        chk("irq", 32'h0, irq);
    endtask : t_sup

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_event = '0;
        trap_event = '0;
        accept_en = 1'b0;
        stall = 1'b0;
        slow = 1'b0;
        ret_go = 1'b0;
        ret_lvl = 4'h0;
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        foreach (pr_m[i]) pr_m[i] = 32'h0;
        foreach (en_m[i]) en_m[i] = 32'h0;
        foreach (fl_m[i]) fl_m[i] = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        rst();
        t_prio();
        rst();
        t_trap();
        rst();
        t_nest();
        rst();
        t_nstd();
        rst();
        t_sup();
        close_out();
    end
endmodule : tb_priority_interrupt_trap_arbiter
